// ===== pkg/mode_map_pkg.sv
// Purpose: Shared constants for the operating mode and memory map control block
// Assumes: AXI4-Lite register access, 32-bit data, registers in the low byte
// Notes:   Printed offsets are not all multiples of four, so they are indices
package mode_map_pkg;

   // ------------------------------------------------------------------
   // Register indices and address width
   // ------------------------------------------------------------------
   localparam logic [11:0] idx_operating_mode   = 12'h004;
   localparam logic [11:0] idx_memory_map_wait  = 12'h005;
   localparam logic [11:0] idx_upper_rom_window = 12'h010;
   localparam logic [11:0] idx_flash_control    = 12'h221;
   localparam logic [11:0] idx_write_protect    = 12'h00a;
   localparam logic [11:0] idx_flash_control0   = 12'h220;
   localparam logic [11:0] idx_access_status    = 12'h300;
   localparam int          addr_width           = 14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int mode_select_lsb        = 0;
   localparam int data_flash_map_bit     = 0;
   localparam int sticky_set_pos         = 2;
   localparam int software_wait_pos      = 7;
   localparam int data_flash_wait_pos    = 7;
   localparam int upper_rom_disable_pos  = 0;
   localparam int mode_unlock_pos        = 1;
   localparam int rom_unlock_pos         = 6;
   localparam int cpu_rewrite_pos        = 1;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] operating_mode_reset   = 8'h00;
   localparam logic [7:0] memory_map_wait_reset  = 8'h08;
   localparam logic [7:0] upper_rom_window_reset = 8'h00;
   localparam logic [7:0] flash_control_reset    = 8'h00;
   localparam logic [7:0] write_protect_reset    = 8'h00;
   localparam logic [1:0] single_chip_mode       = 2'h0;

   // ------------------------------------------------------------------
   // Address map of the internal space
   // ------------------------------------------------------------------
   localparam logic [19:0] data_flash_a_lo = 20'h0e000;
   localparam logic [19:0] data_flash_a_hi = 20'h0efff;
   localparam logic [19:0] data_flash_b_lo = 20'h0f000;
   localparam logic [19:0] data_flash_b_hi = 20'h0ffff;
   localparam logic [19:0] upper_rom_lo    = 20'h10000;
   localparam logic [19:0] upper_rom_hi    = 20'h13fff;
   localparam logic [19:0] sfr_hi          = 20'h003ff;
   localparam logic [19:0] ram_hi          = 20'h0bfff;
   localparam logic [19:0] rom1_lo         = 20'hc0000;

   // Access area classes seen by the wait-state logic
   typedef enum logic [2:0] {
      area_none, area_sfr, area_ram, area_data_flash, area_rom
   } area_t;

   localparam logic [1:0] resp_okay   = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== rtl/area_decoder.sv
// Purpose: Classifies an internal bus address into an access area and wait count
// Assumes: Single-chip mode, 20-bit internal address
// Notes:   Purely combinational; caller registers the results
`timescale 1ns/1ps
module area_decoder (
   input  wire logic [19:0]         addr,
   input  wire logic                data_flash_on,
   input  wire logic                upper_rom_off,
   input  wire logic                soft_wait,
   input  wire logic                flash_wait,
   output      mode_map_pkg::area_t area,
   output      logic                wait_one
);
   import mode_map_pkg::*;

   // Only SFR, RAM and ROM exist; nothing decodes to an external area
   always_comb begin
      area     = area_none;
      wait_one = 1'b0;
      if (addr <= sfr_hi) begin
         area     = area_sfr;
         wait_one = 1'b1;                          // SFR always one wait
      end else if (addr <= ram_hi) begin
         area     = area_ram;
         wait_one = soft_wait;                     // RL13
      end else if (addr >= data_flash_a_lo && addr <= data_flash_b_hi) begin
         // Both blocks usable whenever the map is enabled
         if (data_flash_on) begin                  // RL7 RL8
            area     = area_data_flash;
            // Flash wait bit low means forced wait; either bit adds one
            wait_one = soft_wait | ~flash_wait;    // RL14
         end
      end else if (addr >= upper_rom_lo && addr <= upper_rom_hi) begin
         if (!upper_rom_off) begin                 // RL11 RL16
            area     = area_rom;
            wait_one = soft_wait;                  // RL13
         end
      end else if (addr >= rom1_lo) begin
         area     = area_rom;
         wait_one = soft_wait;
      end
   end
endmodule

// ===== rtl/mode_map_control.sv
// Purpose: Operating mode, memory map and software wait control registers
// Assumes: AXI4-Lite slave, one write and one read at a time, ref_clk 50 MHz
// Notes:   Byte address is four times the register index
//
// What this block does
// RL1: Only single-chip mode exists; the mode field offers nothing else.
// RL2: Decoded space holds only SFR, internal RAM and internal ROM.
// RL3: No pin ever becomes an external bus pin; external bus enable stays low.
// RL4: Software must always write zero-zero to the mode select field.
// RL5: Both mode registers change only while the mode unlock bit is one.
// RL6: Sticky bit sets on writing one; writing zero leaves it until reset.
// RL7: Data flash enable maps data flash at 0E000h to 0FFFFh.
// RL8: Enabled data flash exposes block A and block B together.
// RL9: Data flash enable reads one and is forced one during CPU rewrite mode.
// RL10: Upper ROM window register changes only while the ROM unlock bit is one.
// RL11: Bit 0 of the upper ROM window register controls mapping at 10000h-13FFFh.
// RL12: Internal bus is 16 bits, separate paths, zero or one software wait.
// RL13: Wait select stretches RAM and program ROM accesses to two cycles.
// RL14: Either wait bit adds one wait state to data flash reads.
// RL15: Writes to a locked register are dropped, contents unchanged.
// RL16: Upper ROM bit zero maps the window, one removes it.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module mode_map_control (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic [mode_map_pkg::addr_width-1:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [mode_map_pkg::addr_width-1:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [19:0] bus_addr,
   input  wire logic        bus_req,
   output      logic        data_flash_mapped,
   output      logic        upper_rom_mapped,
   output      logic        bus_wait,
   output      logic        bus_area_valid,
   output      logic        external_bus_enable
);
   import mode_map_pkg::*;

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0]  operating_mode_control;
   logic [7:0]  memory_map_wait_control;
   logic [7:0]  upper_rom_window_control;
   logic [7:0]  flash_control_one;
   logic [7:0]  flash_control_zero;
   logic [7:0]  write_protect_register;
   logic        aw_held;
   logic        w_held;
   logic [mode_map_pkg::addr_width-1:0] aw_addr;
   logic [31:0] w_data;
   logic        w_lane0;
   logic        wr_fire;
   logic [11:0] wr_idx;
   logic [11:0] rd_idx;
   logic [7:0]  wbyte;
   logic        mode_unlock;
   logic        rom_unlock;
   logic        cpu_rewrite;
   logic        df_enable;
   area_t       area;
   logic        wait_one;
   logic [7:0]  next_rdata;
   logic        next_rhit;

   assign wr_idx      = aw_addr[addr_width-1:2];
   assign rd_idx      = s_axi_araddr[addr_width-1:2];
   assign wbyte       = w_data[7:0];
   assign wr_fire     = aw_held && w_held && !s_axi_bvalid;
   assign mode_unlock = write_protect_register[mode_unlock_pos];
   assign rom_unlock  = write_protect_register[rom_unlock_pos];
   assign cpu_rewrite = flash_control_zero[cpu_rewrite_pos];
   // Forced high during rewrite so the flash stays visible to the rewriter
   assign df_enable   = memory_map_wait_control[data_flash_map_bit] | cpu_rewrite; // RL9

   // ------------------------------------------------------------------
   // AXI write channels: address and data taken in either order
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= 32'h0;
         w_lane0       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= resp_okay;
      end else if (clk_en) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_idx)
               idx_operating_mode, idx_memory_map_wait, idx_upper_rom_window,
               idx_flash_control, idx_write_protect, idx_flash_control0:
                  s_axi_bresp <= resp_okay;
               default:
                  s_axi_bresp <= resp_slverr;
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Protection register and flash controls: never locked
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_protect_register <= write_protect_reset;
         flash_control_zero     <= flash_control_reset;
         flash_control_one      <= flash_control_reset;
      end else if (clk_en && wr_fire && w_lane0) begin
         if (wr_idx == idx_write_protect) begin
            write_protect_register <= wbyte;
         end
         if (wr_idx == idx_flash_control0) begin
            flash_control_zero <= wbyte;
         end
         if (wr_idx == idx_flash_control) begin
            flash_control_one <= wbyte;
         end
      end
   end

   // ------------------------------------------------------------------
   // Mode registers, guarded by the mode unlock bit
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         operating_mode_control  <= operating_mode_reset;
         memory_map_wait_control <= memory_map_wait_reset;
      end else if (clk_en && wr_fire && w_lane0 && mode_unlock) begin // RL5 RL15
         if (wr_idx == idx_operating_mode) begin
            // Mode field is held at single-chip whatever is written
            operating_mode_control <= {wbyte[7:2], single_chip_mode}; // RL1 RL4
         end
         if (wr_idx == idx_memory_map_wait) begin
            memory_map_wait_control <= wbyte;
            // Once set, the sticky bit ignores zero until reset
            memory_map_wait_control[sticky_set_pos] <=
               wbyte[sticky_set_pos] | memory_map_wait_control[sticky_set_pos]; // RL6
         end
      end
   end

   // ------------------------------------------------------------------
   // Upper ROM window register, guarded by the ROM unlock bit
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_rom_window_control <= upper_rom_window_reset;
      end else if (clk_en && wr_fire && w_lane0 && rom_unlock &&
                   wr_idx == idx_upper_rom_window) begin // RL10 RL15
         upper_rom_window_control <= {6'h00, wbyte[1:0]};
      end
   end

   // ------------------------------------------------------------------
   // Read path: one read at a time, answer two cycles after arvalid
   // ------------------------------------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      next_rhit  = 1'b1;
      case (rd_idx)
         idx_operating_mode:   next_rdata = operating_mode_control;
         idx_memory_map_wait:  next_rdata = {memory_map_wait_control[7:1], df_enable}; // RL9
         idx_upper_rom_window: next_rdata = upper_rom_window_control;
         idx_flash_control:    next_rdata = flash_control_one;
         idx_write_protect:    next_rdata = write_protect_register;
         idx_flash_control0:   next_rdata = flash_control_zero;
         idx_access_status:    next_rdata = {4'h0, bus_wait, bus_area_valid,
                                             upper_rom_mapped, data_flash_mapped};
         default:              next_rhit  = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= resp_okay;
      end else if (clk_en) begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, next_rdata};
            s_axi_rresp  <= next_rhit ? resp_okay : resp_slverr;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Internal 16-bit bus area decode and wait insertion
   // ------------------------------------------------------------------
   area_decoder u_area_decoder (
      .addr          (bus_addr),
      .data_flash_on (df_enable),
      .upper_rom_off (upper_rom_window_control[upper_rom_disable_pos]),
      .soft_wait     (memory_map_wait_control[software_wait_pos]),
      .flash_wait    (flash_control_one[data_flash_wait_pos]),
      .area          (area),
      .wait_one      (wait_one)
   );

   // Registered decode results: wait is zero or one state only
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_wait            <= 1'b0;
         bus_area_valid      <= 1'b0;
         data_flash_mapped   <= 1'b0;
         upper_rom_mapped    <= 1'b0;
         external_bus_enable <= 1'b0;
      end else if (clk_en) begin
         bus_wait            <= bus_req && wait_one;                     // RL12 RL13 RL14
         bus_area_valid      <= bus_req && (area != area_none);          // RL2
         data_flash_mapped   <= df_enable;                               // RL7 RL8
         upper_rom_mapped    <= !upper_rom_window_control[upper_rom_disable_pos]; // RL11 RL16
         external_bus_enable <= 1'b0;                                    // RL3
      end
   end
endmodule

// ===== testbench/mode_map_control_properties.sv
// Purpose: Port-level properties of the mode and memory map control block
// Assumes: One clock domain, reset_n asynchronous and active low
// Notes:   Bound to the top module and sees only its ports
`timescale 1ns/1ps
module mode_map_control_check (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [19:0] bus_addr,
   input wire logic        bus_req,
   input wire logic        data_flash_mapped,
   input wire logic        upper_rom_mapped,
   input wire logic        bus_wait,
   input wire logic        bus_area_valid,
   input wire logic        external_bus_enable
);
   import mode_map_pkg::*;
   // ------------------------------------------------------------------
   // Request classes
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence sfr_req;   bus_req && bus_addr <= sfr_hi; endsequence
   sequence flash_req;
      bus_req && bus_addr >= data_flash_a_lo && bus_addr <= data_flash_b_hi;
   endsequence
   sequence rom2_req;  bus_req && bus_addr >= upper_rom_lo && bus_addr <= upper_rom_hi; endsequence
   sequence read_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence write_taken; s_axi_awvalid && s_axi_awready; endsequence
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   // Single-chip only, so the external bus must never come up
   a_no_external_bus: assert property (!external_bus_enable)
      else $error("external bus enabled");
   a_sfr_one_wait: assert property (sfr_req |=> bus_area_valid && bus_wait)
      else $error("register area decode or wait wrong");
   // Map flags and decode register the same enable, so they agree on the same edge
   a_flash_map_on: assert property (flash_req |=> !data_flash_mapped || bus_area_valid)
      else $error("mapped data flash not decoded");
   a_flash_map_off: assert property (flash_req |=> data_flash_mapped || !bus_area_valid)
      else $error("unmapped data flash decoded");
   a_rom2_follows: assert property (rom2_req |=> bus_area_valid == upper_rom_mapped)
      else $error("upper rom decode disagrees with map bit");
   a_write_answer: assert property (write_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (read_taken |-> ##[1:3] s_axi_rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
                                  |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule
bind mode_map_control mode_map_control_check u_check (.ref_clk(ref_clk), .reset_n(reset_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .bus_addr(bus_addr), .bus_req(bus_req), .data_flash_mapped(data_flash_mapped),
   .upper_rom_mapped(upper_rom_mapped), .bus_wait(bus_wait), .bus_area_valid(bus_area_valid),
   .external_bus_enable(external_bus_enable));

// ===== testbench/test_mode_map_control.sv
// Purpose: Register and decode tests for the mode and memory map control block
// Assumes: AXI4-Lite master in the bench, clk_en held high
// Notes:   Field checks are masked where other bits are not defined
`timescale 1ns/1ps
module test_mode_map_control;
   import mode_map_pkg::*;
   logic                  ref_clk = 1'h0;
   logic                  reset_n = 1'h0;
   logic [addr_width-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
   logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, bus_req = 1'h0;
   logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]            s_axi_bresp, s_axi_rresp;
   logic [19:0]           bus_addr = 20'h0;
   logic                  data_flash_mapped, upper_rom_mapped, bus_wait, bus_area_valid;
   logic                  external_bus_enable;
   logic [19:0]           flash_ends [4] = '{data_flash_a_lo, data_flash_a_hi, data_flash_b_lo,
                                             data_flash_b_hi};
   int                    fail_count = 0, tests_run = 0;

   mode_map_control u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'h1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .bus_addr(bus_addr),
      .bus_req(bus_req), .data_flash_mapped(data_flash_mapped),
      .upper_rom_mapped(upper_rom_mapped), .bus_wait(bus_wait), .bus_area_valid(bus_area_valid),
      .external_bus_enable(external_bus_enable));

   // ------------------------------------------------------------------
   // Clock, verdict and bus tasks
   // ------------------------------------------------------------------
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      if (fail_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Address and data offered together, each released once taken
   // Ready comes a cycle after the answer, so the slave must hold it
   task automatic wr(input logic [11:0] idx, input logic [7:0] val,
                     input logic [1:0] exp_resp = resp_okay);
      @(posedge ref_clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, val};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) break;
         if (s_axi_bvalid === 1'h1) s_axi_bready <= 1'h1;
      end
      s_axi_bready <= 1'h0;
      check({6'h0, s_axi_bresp}, {6'h0, exp_resp}, "write response");
   endtask

   task automatic rdchk(input logic [11:0] idx, input logic [7:0] mask, input logic [7:0] exp,
                        input logic [1:0] exp_resp = resp_okay);
      @(posedge ref_clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1) break;
         if (s_axi_rvalid === 1'h1) s_axi_rready <= 1'h1;
      end
      s_axi_rready <= 1'h0;
      check(s_axi_rdata[7:0] & mask, exp, "register read");
      check({6'h0, s_axi_rresp}, {6'h0, exp_resp}, "read response");
   endtask

   // One internal access; results land one cycle later
   task automatic dec(input logic [19:0] a, input logic exp_valid, input logic exp_wait);
      @(posedge ref_clk);
      bus_req <= 1'h1;
      bus_addr <= a;
      @(posedge ref_clk);
      bus_req <= 1'h0;
      #1;
      check({7'h0, bus_area_valid}, {7'h0, exp_valid}, "area valid");
      if (exp_valid) check({7'h0, bus_wait}, {7'h0, exp_wait}, "bus wait");
   endtask

   task automatic flags(input logic dfm, input logic urm);
      check({7'h0, data_flash_mapped}, {7'h0, dfm}, "data flash mapped");
      check({7'h0, upper_rom_mapped}, {7'h0, urm}, "upper rom mapped");
   endtask

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      stop_test();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'h1;
      rdchk(idx_operating_mode, 8'hff, 8'h00);
      rdchk(idx_memory_map_wait, 8'hff, 8'h08);
      rdchk(idx_upper_rom_window, 8'hff, 8'h00);
      flags(1'h0, 1'h1);
      wr(idx_memory_map_wait, 8'h0d);
      rdchk(idx_memory_map_wait, 8'hff, 8'h08);
      wr(idx_write_protect, 8'h02);
      wr(idx_operating_mode, 8'h03);
      rdchk(idx_operating_mode, 8'h03, 8'h00);
      wr(idx_memory_map_wait, 8'h0d);
      rdchk(idx_memory_map_wait, 8'h05, 8'h05);
      flags(1'h1, 1'h1);
      // Flash wait bit still zero, so every flash read costs a wait
      for (int i = 0; i < 4; i++) dec(flash_ends[i], 1'h1, 1'h1);
      wr(idx_memory_map_wait, 8'h08);
      rdchk(idx_memory_map_wait, 8'h05, 8'h04);
      flags(1'h0, 1'h1);
      dec(data_flash_a_lo, 1'h0, 1'h0);
      wr(idx_flash_control0, 8'h02);
      rdchk(idx_memory_map_wait, 8'h01, 8'h01);
      wr(idx_memory_map_wait, 8'h08);
      rdchk(idx_memory_map_wait, 8'h01, 8'h01);
      flags(1'h1, 1'h1);
      wr(idx_flash_control0, 8'h00);
      rdchk(idx_memory_map_wait, 8'h01, 8'h00);
      wr(idx_flash_control, 8'h80);
      wr(idx_memory_map_wait, 8'h01);
      dec(data_flash_b_hi, 1'h1, 1'h0);
      dec(20'h00400, 1'h1, 1'h0);
      dec(sfr_hi, 1'h1, 1'h1);
      wr(idx_memory_map_wait, 8'h81);
      dec(20'h00400, 1'h1, 1'h1);
      dec(data_flash_a_lo, 1'h1, 1'h1);
      dec(upper_rom_lo, 1'h1, 1'h1);
      wr(idx_upper_rom_window, 8'h01);
      rdchk(idx_upper_rom_window, 8'h01, 8'h00);
      wr(idx_write_protect, 8'h42);
      wr(idx_upper_rom_window, 8'h01);
      rdchk(idx_upper_rom_window, 8'h01, 8'h01);
      flags(1'h1, 1'h0);
      dec(upper_rom_hi, 1'h0, 1'h0);
      wr(idx_upper_rom_window, 8'h00);
      rdchk(idx_upper_rom_window, 8'h01, 8'h00);
      dec(upper_rom_hi, 1'h1, 1'h1);
      dec(20'h14000, 1'h0, 1'h0);
      // Status: both maps on, no access pending
      rdchk(idx_access_status, 8'h0f, 8'h03);
      rdchk(12'h0ff, 8'hff, 8'h00, resp_slverr);
      wr(12'h0ff, 8'h00, resp_slverr);
      check({7'h0, external_bus_enable}, 8'h00, "external bus");
      stop_test();
   end
endmodule
